// ### core/nco_pkg.sv
// shared constants and types for the oscillator register block
package nco_pkg;

  localparam int NCO_AW = 3;
  localparam int NCO_DW = 8;
  localparam int NCO_ACC_W = 20;
  localparam int NCO_INC_W = 16;
  localparam int NCO_PWS_W = 3;
  localparam int NCO_PCNT_W = 8;
  localparam int NCO_NSRC = 4;

  // register offsets, one byte register per address
  localparam logic [NCO_AW-1:0] OFS_CTRL = 3'h0;
  localparam logic [NCO_AW-1:0] OFS_CLK = 3'h1;
  localparam logic [NCO_AW-1:0] OFS_ACCL = 3'h2;
  localparam logic [NCO_AW-1:0] OFS_ACCH = 3'h3;
  localparam logic [NCO_AW-1:0] OFS_ACCU = 3'h4;
  localparam logic [NCO_AW-1:0] OFS_INCL = 3'h5;
  localparam logic [NCO_AW-1:0] OFS_INCH = 3'h6;

  // control register bit positions
  localparam int CTRL_EN = 7;
  localparam int CTRL_OE = 6;
  localparam int CTRL_OUT = 5;
  localparam int CTRL_POL = 4;
  localparam int CTRL_PFM = 0;

  // clock control field positions
  localparam int CLK_PWS_LSB = 5;
  localparam int CLK_CKS_LSB = 0;

  // writable bits per register
  localparam logic [NCO_DW-1:0] CTRL_WMASK = 8'hD1;
  localparam logic [NCO_DW-1:0] CLK_WMASK = 8'hE3;
  localparam logic [NCO_DW-1:0] ACCU_WMASK = 8'h0F;

  // values after any reset
  localparam logic [NCO_DW-1:0] RST_CTRL = 8'h00;
  localparam logic [NCO_DW-1:0] RST_CLK = 8'h00;
  localparam logic [NCO_ACC_W-1:0] RST_ACC = 20'h0_0000;
  localparam logic [NCO_DW-1:0] RST_INCL = 8'h01;
  localparam logic [NCO_DW-1:0] RST_INCH = 8'h00;
  localparam logic [NCO_PCNT_W-1:0] RST_PCNT = 8'h00;

  typedef enum logic [1:0] {
    NCO_SRC_FAST = 2'b00,
    NCO_SRC_SYS = 2'b01,
    NCO_SRC_CELL = 2'b10,
    NCO_SRC_PIN = 2'b11
  } nco_src_t;

  typedef enum logic [1:0] {
    NCO_PS_IDLE = 2'b01,
    NCO_PS_PULSE = 2'b10
  } nco_pstate_t;

  // pulse length in source periods: two to the power of the code
  function automatic logic [NCO_PCNT_W-1:0] nco_pulse_len(input logic [NCO_PWS_W-1:0] pws);
    nco_pulse_len = NCO_PCNT_W'(1) << pws;
  endfunction

endpackage

// ### core/nco_shape_if.sv
// carrier between the accumulator and the output shaper
`timescale 1ns/1ps
interface nco_shape_if;
  logic tick;
  logic ovf;
  logic enable;
  logic pfm;
  logic [2:0] pws;
  logic level;

  modport accum (output tick, output ovf, output enable, output pfm, output pws, input level);
  modport shaper (input tick, input ovf, input enable, input pfm, input pws, output level);
endinterface

// ### core/nco_sync_edge.sv
// two-stage synchronisers with rising edge detect for the clock sources
`timescale 1ns/1ps
module nco_sync_edge #(
  parameter int N = 4
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [N-1:0] async_in,
  output logic [N-1:0] rise
);
  // one private chain per source, so no vector has several writers
  for (genvar i = 0; i < N; i++) begin : g_sync
    logic s1_ff;
    logic s2_ff;
    logic s3_ff;
    always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
        s1_ff <= 1'b0;
        s2_ff <= 1'b0;
        s3_ff <= 1'b0;
      end else begin
        s1_ff <= async_in[i];
        s2_ff <= s1_ff;
        s3_ff <= s2_ff;
      end
    end
    // edge seen only after both stages
    assign rise[i] = s2_ff & ~s3_ff;
  end
endmodule

// ### core/nco_pulse_shaper.sv
// turns accumulator overflows into a toggled or pulsed output level
`timescale 1ns/1ps
module nco_pulse_shaper (
  input wire logic ref_clk,
  input wire logic rst,
  nco_shape_if.shaper sh
);
  import nco_pkg::*;

  nco_pstate_t state_ff;
  nco_pstate_t nxt_state;
  logic [NCO_PCNT_W-1:0] cnt_ff;
  logic [NCO_PCNT_W-1:0] nxt_cnt;
  logic toggle_ff;
  logic nxt_toggle;

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_toggle = toggle_ff;
    if (!sh.enable) begin
      nxt_state = NCO_PS_IDLE;
      nxt_cnt = RST_PCNT;
      nxt_toggle = 1'b0;
    end else begin
      case (state_ff)
        NCO_PS_IDLE: begin
          // width field matters only in pulse mode
          if (sh.ovf && sh.pfm) begin
            nxt_state = NCO_PS_PULSE;
            nxt_cnt = nco_pulse_len(sh.pws);
          end else if (sh.ovf) begin
            nxt_toggle = ~toggle_ff;
          end
        end
        NCO_PS_PULSE: begin
          // overflow inside a pulse is not handled
          if (sh.tick) begin
            nxt_cnt = cnt_ff - NCO_PCNT_W'(1);
            if (cnt_ff == NCO_PCNT_W'(1)) begin
              nxt_state = NCO_PS_IDLE;
            end
          end
        end
        default: begin
          nxt_state = NCO_PS_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_ff <= NCO_PS_IDLE;
      cnt_ff <= RST_PCNT;
      toggle_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      toggle_ff <= nxt_toggle;
    end
  end

  // pulse mode: high for the pulse; fixed duty: toggle level
  assign sh.level = sh.pfm ? (state_ff == NCO_PS_PULSE) : toggle_ff;
endmodule

// ### core/nco_regs.sv
// numerically controlled oscillator: registers, source select, accumulator
`timescale 1ns/1ps
module nco_regs (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [nco_pkg::NCO_AW-1:0] reg_addr,
  input wire logic [nco_pkg::NCO_DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [nco_pkg::NCO_DW-1:0] reg_rdata,
  input wire logic fast_internal_oscillator,
  input wire logic system_clock_in,
  input wire logic logic_cell_output,
  input wire logic external_clock_pin_input,
  output logic nco_signal,
  output logic nco_pin_out,
  output logic nco_pin_oe_n
);
  import nco_pkg::*;

  // register state
  logic [NCO_DW-1:0] ctrl_ff;
  logic [NCO_DW-1:0] clk_ctrl_ff;
  logic [NCO_ACC_W-1:0] phase_accumulator_ff;
  logic [NCO_ACC_W-1:0] nxt_phase_accumulator;
  logic [NCO_DW-1:0] phase_step_low_ff;
  logic [NCO_DW-1:0] phase_step_high_ff;
  logic [NCO_DW-1:0] rdata_ff;
  logic [NCO_DW-1:0] nxt_rdata;
  logic signal_ff;
  logic pin_out_ff;
  logic pin_oe_n_ff;

  // address decode
  wire hit_ctrl = (reg_addr == OFS_CTRL);
  wire hit_clk = (reg_addr == OFS_CLK);
  wire hit_accl = (reg_addr == OFS_ACCL);
  wire hit_acch = (reg_addr == OFS_ACCH);
  wire hit_accu = (reg_addr == OFS_ACCU);
  wire hit_incl = (reg_addr == OFS_INCL);
  wire hit_inch = (reg_addr == OFS_INCH);

  wire wr_ctrl = reg_wr & hit_ctrl;
  wire wr_clk = reg_wr & hit_clk;
  wire wr_accl = reg_wr & hit_accl;
  wire wr_acch = reg_wr & hit_acch;
  wire wr_accu = reg_wr & hit_accu;
  wire wr_incl = reg_wr & hit_incl;
  wire wr_inch = reg_wr & hit_inch;
  wire wr_acc_any = wr_accl | wr_acch | wr_accu;

  // control fields
  wire module_enable_bit = ctrl_ff[CTRL_EN];
  wire output_enable_bit = ctrl_ff[CTRL_OE];
  wire output_polarity_bit = ctrl_ff[CTRL_POL];
  wire pulse_freq_mode_bit = ctrl_ff[CTRL_PFM];
  wire [NCO_PWS_W-1:0] pulse_width_select = clk_ctrl_ff[CLK_PWS_LSB +: NCO_PWS_W];
  wire [1:0] input_clock_source_select = clk_ctrl_ff[CLK_CKS_LSB +: 2];
  wire [NCO_INC_W-1:0] phase_step = {phase_step_high_ff, phase_step_low_ff};

  // source synchronisers; all sources are slower than ref_clk
  logic [NCO_NSRC-1:0] src_raw;
  logic [NCO_NSRC-1:0] src_rise;

  assign src_raw[NCO_SRC_FAST] = fast_internal_oscillator;
  assign src_raw[NCO_SRC_SYS] = system_clock_in;
  assign src_raw[NCO_SRC_CELL] = logic_cell_output;
  assign src_raw[NCO_SRC_PIN] = external_clock_pin_input;

  nco_sync_edge #(
    .N(NCO_NSRC)
  ) u_sync (
    .ref_clk(ref_clk),
    .rst(rst),
    .async_in(src_raw),
    .rise(src_rise)
  );

  // only the chosen source advances the oscillator
  wire src_tick = src_rise[input_clock_source_select];
  wire run_tick = src_tick & module_enable_bit;

  // accumulate with carry out of the top bit as overflow
  wire [NCO_ACC_W:0] acc_sum = {1'b0, phase_accumulator_ff} + {5'h00, phase_step};
  // a software write to the accumulator wins over a tick in that cycle
  wire acc_ovf = run_tick & ~wr_acc_any & acc_sum[NCO_ACC_W];

  // output shaper
  nco_shape_if sh ();

  assign sh.tick = run_tick;
  assign sh.ovf = acc_ovf;
  assign sh.enable = module_enable_bit;
  assign sh.pfm = pulse_freq_mode_bit;
  assign sh.pws = pulse_width_select;

  nco_pulse_shaper u_shaper (
    .ref_clk(ref_clk),
    .rst(rst),
    .sh(sh)
  );

  // control register; the output bit is status, not stored
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ctrl_ff <= RST_CTRL;
    end else if (wr_ctrl) begin
      ctrl_ff <= reg_wdata & CTRL_WMASK;
    end
  end

  // clock control; bits 4 to 2 never store
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      clk_ctrl_ff <= RST_CLK;
    end else if (wr_clk) begin
      clk_ctrl_ff <= reg_wdata & CLK_WMASK;
    end
  end

  // next accumulator value: byte writes overlay, else add on tick
  always_comb begin
    nxt_phase_accumulator = phase_accumulator_ff;
    if (wr_accl) begin
      nxt_phase_accumulator[7:0] = reg_wdata;
    end else if (wr_acch) begin
      nxt_phase_accumulator[15:8] = reg_wdata;
    end else if (wr_accu) begin
      nxt_phase_accumulator[19:16] = reg_wdata[3:0];
    end else if (run_tick) begin
      nxt_phase_accumulator = acc_sum[NCO_ACC_W-1:0];
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      phase_accumulator_ff <= RST_ACC;
    end else begin
      phase_accumulator_ff <= nxt_phase_accumulator;
    end
  end

  // step registers; low byte comes up as one so the oscillator moves
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      phase_step_low_ff <= RST_INCL;
    end else if (wr_incl) begin
      phase_step_low_ff <= reg_wdata;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      phase_step_high_ff <= RST_INCH;
    end else if (wr_inch) begin
      phase_step_high_ff <= reg_wdata;
    end
  end

  // polarity: raw level high means active
  wire nxt_signal = output_polarity_bit ? sh.level : ~sh.level;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      signal_ff <= 1'b0;
      pin_out_ff <= 1'b0;
      pin_oe_n_ff <= 1'b1;
    end else begin
      signal_ff <= nxt_signal;
      pin_out_ff <= nxt_signal;
      pin_oe_n_ff <= ~output_enable_bit;
    end
  end

  assign nco_signal = signal_ff;
  assign nco_pin_out = pin_out_ff;
  assign nco_pin_oe_n = pin_oe_n_ff;

  // read mux; unmapped addresses return zero
  wire [NCO_DW-1:0] rd_ctrl = (ctrl_ff & CTRL_WMASK) | (NCO_DW'(signal_ff) << CTRL_OUT);
  wire [NCO_DW-1:0] rd_accu = {4'h0, phase_accumulator_ff[19:16]};

  always_comb begin
    nxt_rdata = 8'h00;
    if (!reg_rd) begin
      nxt_rdata = 8'h00;
    end else if (hit_ctrl) begin
      nxt_rdata = rd_ctrl;
    end else if (hit_clk) begin
      nxt_rdata = clk_ctrl_ff & CLK_WMASK;
    end else if (hit_accl) begin
      nxt_rdata = phase_accumulator_ff[7:0];
    end else if (hit_acch) begin
      nxt_rdata = phase_accumulator_ff[15:8];
    end else if (hit_accu) begin
      nxt_rdata = rd_accu & ACCU_WMASK;
    end else if (hit_incl) begin
      nxt_rdata = phase_step_low_ff;
    end else if (hit_inch) begin
      nxt_rdata = phase_step_high_ff;
    end
  end

  // data stands only in the cycle after the read strobe
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rdata_ff <= 8'h00;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign reg_rdata = rdata_ff;
endmodule

// ### verification/nco_regs_checker.sv
// port-level assertions for the oscillator register block
`timescale 1ns/1ps
module nco_regs_checker (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [nco_pkg::NCO_AW-1:0] reg_addr,
  input wire logic [nco_pkg::NCO_DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [nco_pkg::NCO_DW-1:0] reg_rdata,
  input wire logic nco_signal,
  input wire logic nco_pin_out
);
  import nco_pkg::*;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic en_ff;
  logic pol_ff;
  logic [3:0] quiet_ff;
  wire ctrl_wr = reg_wr && reg_addr == OFS_CTRL;
  // any control write restarts the settle count
  wire [3:0] nxt_quiet = (ctrl_wr || en_ff) ? 4'h0 : quiet_ff + {3'h0, quiet_ff != 4'hf};
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      en_ff <= 1'b0;
      pol_ff <= 1'b0;
      quiet_ff <= 4'h0;
    end else begin
      en_ff <= ctrl_wr ? reg_wdata[CTRL_EN] : en_ff;
      pol_ff <= ctrl_wr ? reg_wdata[CTRL_POL] : pol_ff;
      quiet_ff <= nxt_quiet;
    end
  end
  property p_clk_rsvd;
    reg_rd && reg_addr == OFS_CLK |=> reg_rdata[4:2] == 3'h0;
  endproperty
  property p_accu_rsvd;
    reg_rd && reg_addr == OFS_ACCU |=> reg_rdata[7:4] == 4'h0;
  endproperty
  property p_back(logic [NCO_AW-1:0] a, logic [NCO_DW-1:0] m);
    !en_ff && reg_wr && reg_addr == a ##1 reg_rd && reg_addr == a
      |=> reg_rdata == ($past(reg_wdata, 2) & m);
  endproperty
  property p_idle_level;
    quiet_ff > 4'h4 |-> nco_signal == !pol_ff;
  endproperty
  property p_pin_copy;
    nco_pin_out == nco_signal;
  endproperty
  a_clk_rsvd: assert property (p_clk_rsvd)
    else $error("clock control reserved bits set");
  a_accu_rsvd: assert property (p_accu_rsvd)
    else $error("upper accumulator bits set");
  a_clk_rw: assert property (p_back(OFS_CLK, CLK_WMASK))
    else $error("clock control readback");
  a_accu_rw: assert property (p_back(OFS_ACCU, ACCU_WMASK))
    else $error("accum upper readback");
  a_incl_rw: assert property (p_back(OFS_INCL, 8'hff))
    else $error("step low readback");
  a_inch_rw: assert property (p_back(OFS_INCH, 8'hff))
    else $error("step high readback");
  a_idle_level: assert property (p_idle_level)
    else $error("idle output level");
  a_pin_copy: assert property (p_pin_copy)
    else $error("pin differs from signal");
  c_run: cover property (en_ff && $rose(nco_signal));
  c_pfm: cover property (ctrl_wr && reg_wdata[CTRL_PFM]);
  c_accu: cover property (reg_rd && reg_addr == OFS_ACCU);
endmodule

bind nco_regs nco_regs_checker u_nco_regs_checker (
  .ref_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .nco_signal, .nco_pin_out
);

// ### verification/nco_clock_accum_regs_bench.sv
// self-checking bench for the oscillator register block
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin err_count++; \
  $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module nco_clock_accum_regs_bench;
  import nco_pkg::*;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [NCO_AW-1:0] reg_addr = '0;
  logic [NCO_DW-1:0] reg_wdata = '0;
  logic [NCO_DW-1:0] reg_rdata;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic rd_pend = 1'b0;
  logic [3:0] src = '0;
  logic tog = 1'b0;
  logic last = 1'b0;
  logic cnt_on = 1'b0;
  logic nco_signal;
  logic nco_pin_out;
  logic nco_pin_oe_n;
  logic [NCO_DW-1:0] exp_v;
  logic [15:0] rnd = 16'hb89e;
  logic [NCO_DW-1:0] exp_q[$];
  int err_count = 0;
  int compares = 0;
  int chg = 0;
  int hi = 0;
  int sel = 0;
  nco_regs u_nco_regs (
    .ref_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .fast_internal_oscillator(src[0]), .system_clock_in(src[1]), .logic_cell_output(src[2]),
    .external_clock_pin_input(src[3]), .nco_signal, .nco_pin_out, .nco_pin_oe_n
  );
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  always #5 ref_clk = ~ref_clk;
  // unselected sources carry noise that must not reach the accumulator
  always @(posedge ref_clk) begin
    rnd <= lfsr(rnd);
    src <= (rnd[3:0] & ~(4'h1 << sel)) | ({3'h0, tog} << sel);
    rd_pend <= reg_rd;
    last <= nco_signal;
    // counters have this one writer; cycles with cnt_on low clear them
    if (cnt_on) begin
      chg <= chg + (nco_signal != last);
      hi <= hi + nco_signal;
    end else begin
      chg <= 0;
      hi <= 0;
    end
  end
  // pop once, so a mismatch cannot shift the queue
  always @(negedge ref_clk) begin
    if (rd_pend) begin
      exp_v = exp_q.pop_front();
      `CHK(reg_rdata, exp_v)
    end
  end
  task automatic wr(input logic [NCO_AW-1:0] a, input logic [NCO_DW-1:0] d);
    reg_wr <= 1'b1;
    reg_rd <= 1'b0;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
  endtask
  task automatic rd(input logic [NCO_AW-1:0] a, input logic [NCO_DW-1:0] e);
    exp_q.push_back(e);
    reg_rd <= 1'b1;
    reg_wr <= 1'b0;
    reg_addr <= a;
    @(posedge ref_clk);
  endtask
  task automatic idle(input int n);
    reg_rd <= 1'b0;
    reg_wr <= 1'b0;
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic chk_reset();
    rst <= 1'b1;
    idle(2);
    rst <= 1'b0;
    idle(1);
    rd(OFS_CTRL, 8'h20);
    rd(OFS_CLK, 8'h00);
    rd(OFS_ACCL, 8'h00);
    rd(OFS_ACCH, 8'h00);
    rd(OFS_ACCU, 8'h00);
    rd(OFS_INCL, 8'h01);
    rd(OFS_INCH, 8'h00);
    rd(3'h7, 8'h00);
    idle(2);
    `CHK(nco_pin_oe_n, 1'b1)
    $display("test reset values done");
  endtask
  task automatic rw_loop();
    logic [NCO_AW-1:0] a;
    logic [NCO_DW-1:0] d;
    logic [NCO_DW-1:0] m[8];
    m = '{8'h00, CLK_WMASK, 8'hff, 8'hff, ACCU_WMASK, 8'hff, 8'hff, 8'h00};
    for (int c = 0; c < 8; c++) begin
      d = {c[2:0], c[2:0], c[1:0]};
      wr(OFS_CLK, d);
      rd(OFS_CLK, d & CLK_WMASK);
    end
    for (int i = 0; i < 32; i++) begin
      a = (rnd[2:0] == 3'h0) ? 3'h7 : rnd[2:0];
      d = rnd[15:8];
      wr(a, d);
      rd(a, d & m[a]);
    end
    idle(2);
    $display("test register access done");
  endtask
  // step c000h from zero: one carry at tick 22, 0e0000h after 40 ticks
  task automatic run(input int s, input logic pfm, input logic [2:0] pws, input int nc, input int nh);
    sel = s;
    wr(OFS_ACCL, 8'h00);
    wr(OFS_ACCH, 8'h00);
    wr(OFS_ACCU, 8'h00);
    wr(OFS_INCL, 8'h00);
    wr(OFS_INCH, 8'hc0);
    wr(OFS_CLK, {pws, 3'h0, s[1:0]});
    wr(OFS_CTRL, 8'h50 | {7'h0, pfm});
    idle(6);
    `CHK(nco_signal, 1'b0)
    `CHK(nco_pin_oe_n, 1'b0)
    wr(OFS_CTRL, 8'hd0 | {7'h0, pfm});
    idle(1);
    cnt_on <= 1'b1;
    repeat (40) begin
      tog <= 1'b1;
      idle(4);
      tog <= 1'b0;
      idle(4);
    end
    idle(8);
    cnt_on <= 1'b0;
    `CHK(chg, nc)
    if (pfm) `CHK(hi, nh)
    wr(OFS_CTRL, 8'h50);
    rd(OFS_ACCL, 8'h00);
    rd(OFS_ACCH, 8'h00);
    rd(OFS_ACCU, 8'h0e);
    idle(2);
    $display("test source %0d mode %0d done", s, pfm);
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge ref_clk);
    err_count++;
    conclude();
  end
  initial begin
    chk_reset();
    rw_loop();
    // a nonzero width in fixed duty must change nothing
    for (int s = 0; s < 4; s++) run(s, 1'b0, 3'h1, 1, 0);
    run(2, 1'b1, 3'h2, 2, 32);
    run(1, 1'b1, 3'h4, 2, 128);
    chk_reset();
    conclude();
  end
endmodule
